// ==== rtl/prpc_interval_timer.sv ====
// free-running per-row refresh timer, one-cycle tick per period
// assumes period_i is static for long stretches; a change takes effect at once on the running count
module prpc_interval_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [prpc_pkg::TMR_W-1:0] period_i,
  output logic tick_o
);

  logic [prpc_pkg::TMR_W-1:0] cnt_r;
  logic [prpc_pkg::TMR_W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    cnt_nxt = cnt_r + 1'b1;
    tick_nxt = 1'b0;
    if (cnt_r >= period_i - 1'b1) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
    if (!rst_n_i || !run_i) begin
      cnt_nxt = '0;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    cnt_r <= cnt_nxt;
    tick_r <= tick_nxt;
  end

  assign tick_o = tick_r;

endmodule : prpc_interval_timer

// ==== rtl/prpc_pkg.sv ====
// constants, types and decode helpers for the refresh and power-state controller
// assumes a 125 MHz core clock; core-cycle counts are derived here from that rate
package prpc_pkg;

  localparam int CORE_CLK_MHZ = 125;

  // array geometry
  localparam int ROW_W = 13;
  localparam int ARRAY_ROWS = 8192;

  // per-row refresh spacing at the default interval setting
  localparam int SPACING_IND_US = 4;
  localparam int SPACING_PLUS_US = 1;
  localparam int TMR_W = 12;
  localparam logic [TMR_W-1:0] SPACING_IND_CYC = TMR_W'(SPACING_IND_US * CORE_CLK_MHZ);
  localparam logic [TMR_W-1:0] SPACING_PLUS_CYC = TMR_W'(SPACING_PLUS_US * CORE_CLK_MHZ);

  // refresh interval field encodings
  localparam logic [1:0] RI_X2 = 2'h0;
  localparam logic [1:0] RI_X4 = 2'h1;
  localparam logic [1:0] RI_X1 = 2'h2;
  localparam logic [1:0] RI_X1P5 = 2'h3;

  // primary and refresh interval config field positions
  localparam int PD_BIT = 15;
  localparam int FIXLAT_BIT = 3;
  localparam int RI_LSB = 0;

  // deep sleep timing
  localparam int SLEEP_ENTRY_US = 10;
  localparam int SLEEP_EXIT_US = 150;
  localparam int PWR_CNT_W = 15;
  localparam logic [PWR_CNT_W-1:0] SLEEP_ENTRY_CYC = PWR_CNT_W'(SLEEP_ENTRY_US * CORE_CLK_MHZ);
  localparam int SLEEP_EXIT_CYC = SLEEP_EXIT_US * CORE_CLK_MHZ;

  // clock stop detection: access time plus margin, rounded up
  localparam int ACC_TIME_NS = 40;
  localparam int CLKSTOP_EXTRA_NS = 30;
  localparam int STALL_W = 4;
  localparam logic [STALL_W-1:0] CLKSTOP_CYC =
    STALL_W'(((ACC_TIME_NS + CLKSTOP_EXTRA_NS) * CORE_CLK_MHZ + 999) / 1000);

  // command-address phase length in link clocks, refresh operation length
  localparam logic [1:0] CA_CLOCKS = 2'h3;
  localparam logic [2:0] REFRESH_OP_CYC = 3'h4;

  typedef struct packed {
    logic power_up_n;
    logic fixed_latency;
    logic [1:0] refresh_interval;
  } prpc_cfg_t;

  localparam prpc_cfg_t CFG_RESET = '{power_up_n: 1'b1, fixed_latency: 1'b1,
                                      refresh_interval: RI_X1};

  typedef struct packed {
    logic sel_refresh;
    logic [15:0] data;
  } prpc_wr_t;

  typedef enum {PWR_ACTIVE, PWR_ENTRY, PWR_DEEP, PWR_WAKE} prpc_pwr_t;
  typedef enum {REF_IDLE, REF_BUSY} prpc_ref_t;

  // per-row spacing in core cycles for an interval code and temperature range
  function automatic logic [TMR_W-1:0] prpc_spacing(input logic [1:0] code, input logic plus);
    logic [TMR_W-1:0] base;
    base = plus ? SPACING_PLUS_CYC : SPACING_IND_CYC;
    case (code)
      RI_X1: prpc_spacing = base;
      RI_X1P5: prpc_spacing = base + (base >> 1);
      RI_X2: prpc_spacing = base << 1;
      RI_X4: prpc_spacing = base << 2;
      default: prpc_spacing = base;
    endcase
  endfunction : prpc_spacing

endpackage : prpc_pkg

// ==== rtl/prpc_refresh_power_ctrl.sv ====
// refresh scheduler, latency strobe and power-state logic of a ddr pseudo-static ram
// assumes a command decoder on the link clock feeds register writes and row addresses,
// and that the array itself acts on the refresh and write-back outputs
//
// Contract
// - refresh waits until host access ends
// - strobe high in command phase if refreshing
// - high strobe means doubled initial latency
// - single-row refreshes spread evenly
// - all 8192 rows within array interval
// - interval field default 10b, 4/1 us
// - 11b 1.5x, 00b 2x, 01b 4x
// - each access writes its row back
// - select high: standby, ignore other inputs
// - stable clock in data: enter clock stop
// - toggling clock resumes normal transfer
// - power-down bit zero: deep sleep, refresh stops
// - select pulse wakes; dummy transaction discarded
// - deep sleep watches select and reset only
// - wake reaches standby in power-on state
module prpc_refresh_power_ctrl #(
  parameter int SLEEP_EXIT_CYCLES = prpc_pkg::SLEEP_EXIT_CYC,
  parameter bit PLUS_RANGE = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic cs_n_i,
  input wire logic hw_reset_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_sel_refresh_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic ca_row_vld_i,
  input wire logic [prpc_pkg::ROW_W-1:0] ca_row_i,
  output logic read_write_strobe_o,
  output logic read_write_strobe_oe_o,
  output logic extra_latency_o,
  output logic refresh_busy_o,
  output logic [prpc_pkg::ROW_W-1:0] refresh_row_o,
  output logic row_writeback_o,
  output logic [prpc_pkg::ROW_W-1:0] writeback_row_o,
  output logic clock_stop_o,
  output logic standby_o,
  output logic deep_sleep_o,
  output logic [15:0] refresh_interval_config_o,
  output logic [15:0] primary_config_o
);

  localparam logic [prpc_pkg::PWR_CNT_W-1:0] EXIT_LAST =
    prpc_pkg::PWR_CNT_W'(SLEEP_EXIT_CYCLES - 1);

  // ---------------- link clock domain ----------------
  logic link_rst_n;
  logic clk_tog_r;
  logic clk_tog_nxt;
  logic wr_tog_r;
  logic wr_tog_nxt;
  prpc_pkg::prpc_wr_t wr_hold_r;
  prpc_pkg::prpc_wr_t wr_hold_nxt;
  logic [prpc_pkg::ROW_W-1:0] row_hold_r;
  logic [prpc_pkg::ROW_W-1:0] row_hold_nxt;

  // link reset only takes effect while the host runs the link clock
  prpc_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b0)) u_link_rst (
    .clk_i(link_clk_i),
    .rst_n_i(1'b1),
    .d_i(rst_n_i),
    .q_o(link_rst_n)
  );

  always_comb begin
    clk_tog_nxt = ~clk_tog_r;
    wr_tog_nxt = wr_tog_r;
    wr_hold_nxt = wr_hold_r;
    row_hold_nxt = row_hold_r;
    if (reg_wr_i && !cs_n_i) begin
      wr_tog_nxt = ~wr_tog_r;
      wr_hold_nxt = '{sel_refresh: reg_sel_refresh_i, data: reg_wdata_i};
    end
    if (ca_row_vld_i && !cs_n_i) begin
      row_hold_nxt = ca_row_i;
    end
    if (!link_rst_n) begin
      clk_tog_nxt = 1'b0;
      wr_tog_nxt = 1'b0;
      wr_hold_nxt = '0;
      row_hold_nxt = '0;
    end
  end

  always_ff @(posedge link_clk_i) begin
    clk_tog_r <= clk_tog_nxt;
    wr_tog_r <= wr_tog_nxt;
    wr_hold_r <= wr_hold_nxt;
    row_hold_r <= row_hold_nxt;
  end

  // ---------------- crossings into the core domain ----------------
  logic cs_n_s;
  logic hw_rst_n_s;
  logic clk_tog_s;
  logic wr_tog_s;

  prpc_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b1)) u_cs_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(cs_n_i),
    .q_o(cs_n_s)
  );

  prpc_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b1)) u_hwrst_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(hw_reset_n_i),
    .q_o(hw_rst_n_s)
  );

  prpc_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b0)) u_clk_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(clk_tog_r),
    .q_o(clk_tog_s)
  );

  prpc_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b0)) u_wr_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(wr_tog_r),
    .q_o(wr_tog_s)
  );

  // ---------------- core domain ----------------
  prpc_pkg::prpc_pwr_t pwr_r;
  prpc_pkg::prpc_pwr_t pwr_nxt;
  logic [prpc_pkg::PWR_CNT_W-1:0] pwr_cnt_r;
  logic [prpc_pkg::PWR_CNT_W-1:0] pwr_cnt_nxt;
  prpc_pkg::prpc_cfg_t cfg_r;
  prpc_pkg::prpc_cfg_t cfg_nxt;
  logic deep_sleep_r;
  logic deep_sleep_nxt;
  logic standby_r;
  logic standby_nxt;

  logic acc_d_r;
  logic clk_tog_d_r;
  logic wr_tog_d_r;
  logic [1:0] ca_cnt_r;
  logic [1:0] ca_cnt_nxt;
  logic read_write_strobe_r;
  logic read_write_strobe_nxt;
  logic read_write_strobe_oe_r;
  logic read_write_strobe_oe_nxt;
  logic xlat_r;
  logic xlat_nxt;
  logic [prpc_pkg::STALL_W-1:0] stall_r;
  logic [prpc_pkg::STALL_W-1:0] stall_nxt;
  logic clock_stop_r;
  logic clock_stop_nxt;
  logic wb_r;
  logic wb_nxt;
  logic [prpc_pkg::ROW_W-1:0] wb_row_r;
  logic [prpc_pkg::ROW_W-1:0] wb_row_nxt;

  prpc_pkg::prpc_ref_t ref_r;
  prpc_pkg::prpc_ref_t ref_nxt;
  logic [2:0] ref_cnt_r;
  logic [2:0] ref_cnt_nxt;
  logic pending_r;
  logic pending_nxt;
  logic busy_r;
  logic busy_nxt;
  logic need_lat_r;
  logic need_lat_nxt;
  logic [prpc_pkg::ROW_W-1:0] row_r;
  logic [prpc_pkg::ROW_W-1:0] row_nxt;

  logic access;
  logic access_end;
  logic link_edge;
  logic wr_evt;
  logic awake;
  logic act_ok;
  logic data_phase;
  logic ref_start;
  logic tick;

  assign access = ~cs_n_s;
  assign access_end = acc_d_r & ~access;
  assign link_edge = clk_tog_s ^ clk_tog_d_r;
  assign wr_evt = wr_tog_s ^ wr_tog_d_r;
  assign awake = (pwr_r == prpc_pkg::PWR_ACTIVE) || (pwr_r == prpc_pkg::PWR_ENTRY);
  assign act_ok = (pwr_r == prpc_pkg::PWR_ACTIVE);
  assign data_phase = access && act_ok && (ca_cnt_r == prpc_pkg::CA_CLOCKS);
  // writeback of the closing access goes first, refresh one cycle later
  // no new refresh in the very cycle that deep sleep or wake is entered
  assign ref_start = (ref_r == prpc_pkg::REF_IDLE) && pending_r && !access && !acc_d_r
                     && !wb_r && awake && (pwr_nxt != prpc_pkg::PWR_DEEP)
                     && (pwr_nxt != prpc_pkg::PWR_WAKE);

  prpc_interval_timer u_timer (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(awake),
    .period_i(prpc_pkg::prpc_spacing(cfg_r.refresh_interval, PLUS_RANGE)),
    .tick_o(tick)
  );

  // power state and configuration
  always_comb begin
    pwr_nxt = pwr_r;
    pwr_cnt_nxt = pwr_cnt_r;
    cfg_nxt = cfg_r;
    case (pwr_r)
      prpc_pkg::PWR_ACTIVE: begin
        if (wr_evt) begin
          if (wr_hold_r.sel_refresh) begin
            // upper bits are reserved and not stored
            cfg_nxt.refresh_interval = wr_hold_r.data[prpc_pkg::RI_LSB +: 2];
          end else begin
            cfg_nxt.fixed_latency = wr_hold_r.data[prpc_pkg::FIXLAT_BIT];
            cfg_nxt.power_up_n = wr_hold_r.data[prpc_pkg::PD_BIT];
            if (!wr_hold_r.data[prpc_pkg::PD_BIT]) begin
              pwr_nxt = prpc_pkg::PWR_ENTRY;
              pwr_cnt_nxt = '0;
            end
          end
        end
      end
      prpc_pkg::PWR_ENTRY: begin
        pwr_cnt_nxt = pwr_cnt_r + 1'b1;
        if (pwr_cnt_r == prpc_pkg::SLEEP_ENTRY_CYC - 1'b1) begin
          pwr_nxt = prpc_pkg::PWR_DEEP;
        end
      end
      prpc_pkg::PWR_DEEP: begin
        // the waking transaction is a dummy: no write, no writeback
        if (access_end) begin
          pwr_nxt = prpc_pkg::PWR_WAKE;
          pwr_cnt_nxt = '0;
          cfg_nxt = prpc_pkg::CFG_RESET;
        end
      end
      prpc_pkg::PWR_WAKE: begin
        pwr_cnt_nxt = pwr_cnt_r + 1'b1;
        if (pwr_cnt_r == EXIT_LAST) begin
          pwr_nxt = prpc_pkg::PWR_ACTIVE;
          cfg_nxt = prpc_pkg::CFG_RESET;
        end
      end
      default: begin
        pwr_nxt = prpc_pkg::PWR_ACTIVE;
      end
    endcase
    if (!hw_rst_n_s) begin
      cfg_nxt = prpc_pkg::CFG_RESET;
      if (pwr_r == prpc_pkg::PWR_DEEP || pwr_r == prpc_pkg::PWR_ENTRY) begin
        pwr_nxt = prpc_pkg::PWR_WAKE;
        pwr_cnt_nxt = '0;
      end
    end
    if (!rst_n_i) begin
      pwr_nxt = prpc_pkg::PWR_ACTIVE;
      pwr_cnt_nxt = '0;
      cfg_nxt = prpc_pkg::CFG_RESET;
    end
    deep_sleep_nxt = (pwr_nxt == prpc_pkg::PWR_DEEP) || (pwr_nxt == prpc_pkg::PWR_WAKE);
    standby_nxt = (pwr_nxt == prpc_pkg::PWR_ACTIVE) && cs_n_s;
  end

  always_ff @(posedge core_clk_i) begin
    pwr_r <= pwr_nxt;
    pwr_cnt_r <= pwr_cnt_nxt;
    cfg_r <= cfg_nxt;
    deep_sleep_r <= deep_sleep_nxt;
    standby_r <= standby_nxt;
  end

  // access phases, strobe, clock stop, writeback
  always_comb begin
    ca_cnt_nxt = ca_cnt_r;
    if (!access) begin
      ca_cnt_nxt = '0;
    end else if (link_edge && ca_cnt_r != prpc_pkg::CA_CLOCKS) begin
      ca_cnt_nxt = ca_cnt_r + 1'b1;
    end
    xlat_nxt = xlat_r;
    if (access && !acc_d_r) begin
      xlat_nxt = act_ok && (cfg_r.fixed_latency || need_lat_r);
    end
    // strobe only driven in the command phase of a live access
    read_write_strobe_oe_nxt = access && act_ok && (ca_cnt_nxt != prpc_pkg::CA_CLOCKS);
    read_write_strobe_nxt = read_write_strobe_oe_nxt && xlat_nxt;
    stall_nxt = stall_r;
    if (!data_phase || link_edge) begin
      stall_nxt = '0;
    end else if (stall_r != prpc_pkg::CLKSTOP_CYC) begin
      stall_nxt = stall_r + 1'b1;
    end
    clock_stop_nxt = (stall_nxt == prpc_pkg::CLKSTOP_CYC);
    wb_nxt = access_end && act_ok && (ca_cnt_r == prpc_pkg::CA_CLOCKS);
    wb_row_nxt = wb_nxt ? row_hold_r : wb_row_r;
    if (!rst_n_i) begin
      ca_cnt_nxt = '0;
      xlat_nxt = 1'b0;
      read_write_strobe_oe_nxt = 1'b0;
      read_write_strobe_nxt = 1'b0;
      stall_nxt = '0;
      clock_stop_nxt = 1'b0;
      wb_nxt = 1'b0;
      wb_row_nxt = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    acc_d_r <= rst_n_i ? access : 1'b0;
    clk_tog_d_r <= rst_n_i ? clk_tog_s : 1'b0;
    wr_tog_d_r <= rst_n_i ? wr_tog_s : 1'b0;
    ca_cnt_r <= ca_cnt_nxt;
    xlat_r <= xlat_nxt;
    read_write_strobe_oe_r <= read_write_strobe_oe_nxt;
    read_write_strobe_r <= read_write_strobe_nxt;
    stall_r <= stall_nxt;
    clock_stop_r <= clock_stop_nxt;
    wb_r <= wb_nxt;
    wb_row_r <= wb_row_nxt;
  end

  // refresh scheduler
  always_comb begin
    ref_nxt = ref_r;
    ref_cnt_nxt = ref_cnt_r;
    row_nxt = row_r;
    // a tick in the cycle the request is taken keeps it pending
    pending_nxt = tick || (pending_r && !ref_start);
    case (ref_r)
      prpc_pkg::REF_IDLE: begin
        if (ref_start) begin
          ref_nxt = prpc_pkg::REF_BUSY;
          ref_cnt_nxt = '0;
        end
      end
      prpc_pkg::REF_BUSY: begin
        ref_cnt_nxt = ref_cnt_r + 1'b1;
        if (ref_cnt_r == prpc_pkg::REFRESH_OP_CYC - 1'b1) begin
          ref_nxt = prpc_pkg::REF_IDLE;
          row_nxt = row_r + 1'b1;
        end
      end
      default: begin
        ref_nxt = prpc_pkg::REF_IDLE;
      end
    endcase
    if (!awake) begin
      pending_nxt = 1'b0;
    end
    if (!rst_n_i) begin
      ref_nxt = prpc_pkg::REF_IDLE;
      ref_cnt_nxt = '0;
      row_nxt = '0;
      pending_nxt = 1'b0;
    end
    busy_nxt = (ref_nxt == prpc_pkg::REF_BUSY);
    need_lat_nxt = busy_nxt || pending_nxt;
  end

  always_ff @(posedge core_clk_i) begin
    ref_r <= ref_nxt;
    ref_cnt_r <= ref_cnt_nxt;
    row_r <= row_nxt;
    pending_r <= pending_nxt;
    busy_r <= busy_nxt;
    need_lat_r <= need_lat_nxt;
  end

  assign read_write_strobe_o = read_write_strobe_r;
  assign read_write_strobe_oe_o = read_write_strobe_oe_r;
  assign extra_latency_o = xlat_r;
  assign refresh_busy_o = busy_r;
  assign refresh_row_o = row_r;
  assign row_writeback_o = wb_r;
  assign writeback_row_o = wb_row_r;
  assign clock_stop_o = clock_stop_r;
  assign standby_o = standby_r;
  assign deep_sleep_o = deep_sleep_r;
  assign refresh_interval_config_o = {14'h0000, cfg_r.refresh_interval};
  assign primary_config_o = {cfg_r.power_up_n, 11'h000, cfg_r.fixed_latency, 3'h0};

endmodule : prpc_refresh_power_ctrl

// ==== rtl/prpc_sync.sv ====
// single-bit synchroniser with optional agreement filter on the last two stages
// assumes d_i is a level from another clock domain or a pin
module prpc_sync #(
  parameter int STAGES = 2,
  parameter bit FILTER = 1'b0,
  parameter bit RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);

  logic [STAGES-1:0] stg_r;
  logic [STAGES-1:0] stg_nxt;
  logic q_r;
  logic q_nxt;

  always_comb begin
    stg_nxt = {stg_r[STAGES-2:0], d_i};
    q_nxt = q_r;
    // a change only counts once the last two stages agree
    if (FILTER) begin
      if (stg_r[STAGES-1] == stg_r[STAGES-2]) begin
        q_nxt = stg_r[STAGES-1];
      end
    end else begin
      q_nxt = stg_r[STAGES-1];
    end
    if (!rst_n_i) begin
      stg_nxt = {STAGES{RST_VAL}};
      q_nxt = RST_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    stg_r <= stg_nxt;
    q_r <= q_nxt;
  end

  assign q_o = q_r;

endmodule : prpc_sync

// ==== verification/prpc_host_model.sv ====
// host side: select, link clock and decoder strobes of one frame
// assumes the bench calls one task at a time
module prpc_host_model (
  output logic link_clk_o,
  output logic cs_n_o,
  output logic reg_wr_o,
  output logic reg_sel_o,
  output logic [15:0] reg_wdata_o,
  output logic ca_row_vld_o,
  output logic [prpc_pkg::ROW_W-1:0] ca_row_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk_o = 1'b0;
    cs_n_o = 1'b1;
    reg_wr_o = 1'b0;
    reg_sel_o = 1'b0;
    reg_wdata_o = 16'hA5A5;
    ca_row_vld_o = 1'b0;
    ca_row_o = '1;
  end
  // clock moves only inside these pulses, still between frames
  task tick(input int n);
    repeat (n) begin
      #16 link_clk_o = 1'b1;
      #16 link_clk_o = 1'b0;
    end
  endtask : tick
  task frame(input logic sel_n, input logic wr, input logic rsel,
             input logic [15:0] d, input int n1, input int stall_ns, input int n2);
    cs_n_o = sel_n;
    #8;
    reg_wr_o = wr;
    reg_sel_o = rsel;
    reg_wdata_o = d;
    ca_row_vld_o = !wr;
    ca_row_o = d[prpc_pkg::ROW_W-1:0];
    tick(1);
    reg_wr_o = 1'b0;
    ca_row_vld_o = 1'b0;
    // released lines show the inverse, not the last value
    reg_wdata_o = ~d;
    ca_row_o = ~d[prpc_pkg::ROW_W-1:0];
    tick(n1);
    #(stall_ns);
    tick(n2);
    cs_n_o = 1'b1;
  endtask : frame
endmodule : prpc_host_model

// ==== verification/prpc_refresh_power_ctrl_chk.sv ====
// output checks for the refresh and power-state controller
// assumes every output is registered on the core clock
module prpc_rpc_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic read_write_strobe_o,
  input wire logic read_write_strobe_oe_o,
  input wire logic extra_latency_o,
  input wire logic refresh_busy_o,
  input wire logic [prpc_pkg::ROW_W-1:0] refresh_row_o,
  input wire logic row_writeback_o,
  input wire logic clock_stop_o,
  input wire logic standby_o,
  input wire logic deep_sleep_o,
  input wire logic [15:0] refresh_interval_config_o,
  input wire logic [15:0] primary_config_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lclk_r;
  logic lclk_nxt;
  logic [3:0] gap_r;
  logic [3:0] gap_nxt;
  // core cycles since the raw link clock moved, saturating
  always_comb begin
    lclk_nxt = link_clk_i;
    gap_nxt = gap_r;
    if (lclk_r != link_clk_i) begin
      gap_nxt = 4'h0;
    end else if (gap_r != 4'hF) begin
      gap_nxt = gap_r + 4'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      lclk_r <= 1'b0;
      gap_r <= 4'h0;
    end else begin
      lclk_r <= lclk_nxt;
      gap_r <= gap_nxt;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_STANDBY_QUIET: assert property (
    standby_o && $past(standby_o) |-> !read_write_strobe_oe_o && !clock_stop_o)
    else $error("strobe or clock stop while deselected");
  AST_BUSY_LEN: assert property (
    $rose(refresh_busy_o) |-> refresh_busy_o [*4] ##1 !refresh_busy_o)
    else $error("refresh length wrong");
  AST_ROW_STEP: assert property (
    $changed(refresh_row_o) && !$past(deep_sleep_o) && !$past(deep_sleep_o, 2)
      |-> refresh_row_o == $past(refresh_row_o) + 13'h1)
    else $error("refresh row skipped");
  AST_NO_REFRESH_IN_ACCESS: assert property (
    $rose(refresh_busy_o) |-> !read_write_strobe_oe_o && !clock_stop_o)
    else $error("refresh during access");
  AST_STROBE_BUSY: assert property (
    $rose(read_write_strobe_oe_o) && $past(refresh_busy_o) |-> read_write_strobe_o)
    else $error("strobe low during refresh");
  AST_STROBE_FIXED: assert property (
    $rose(read_write_strobe_oe_o) |-> read_write_strobe_o == extra_latency_o
      && (read_write_strobe_o || !primary_config_o[prpc_pkg::FIXLAT_BIT]))
    else $error("latency strobe mismatch");
  AST_STROBE_HOLD: assert property (
    read_write_strobe_oe_o && $past(read_write_strobe_oe_o) |-> $stable(read_write_strobe_o))
    else $error("strobe moved in command phase");
  AST_SLEEP_NO_REFRESH: assert property (
    $rose(refresh_busy_o) |-> !deep_sleep_o)
    else $error("refresh in deep sleep");
  AST_SLEEP_QUIET: assert property (
    deep_sleep_o |-> !read_write_strobe_oe_o && !row_writeback_o)
    else $error("activity in deep sleep");
  AST_CLKSTOP_ENTRY: assert property (
    $rose(clock_stop_o) |-> gap_r >= 4'h9)
    else $error("clock stop too early");
  AST_CLKSTOP_EXIT: assert property (
    clock_stop_o && $changed(link_clk_i) |-> ##[1:8] !clock_stop_o)
    else $error("clock stop not left");
  AST_WB_PULSE: assert property (
    row_writeback_o |=> !row_writeback_o)
    else $error("writeback pulse too long");
  AST_WAKE_DEFAULTS: assert property (
    $fell(deep_sleep_o) |-> primary_config_o == 16'h8008
      && refresh_interval_config_o == 16'h0002)
    else $error("wake without defaults");
  AST_RESERVED_ZERO: assert property (
    refresh_interval_config_o[15:2] == 14'h0 && (primary_config_o & 16'h7FF7) == 16'h0)
    else $error("reserved bits set");
endmodule : prpc_rpc_chk
bind prpc_refresh_power_ctrl prpc_rpc_chk u_chk (
  .core_clk_i, .rst_n_i, .link_clk_i, .read_write_strobe_o, .read_write_strobe_oe_o, .extra_latency_o,
  .refresh_busy_o, .refresh_row_o, .row_writeback_o, .clock_stop_o, .standby_o,
  .deep_sleep_o, .refresh_interval_config_o, .primary_config_o
);

// ==== verification/prpc_refresh_power_ctrl_tb_top.sv ====
// self-checking bench: host model frames plus output comparisons
// assumes the checker is bound to the controller
module prpc_refresh_power_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int EXIT_CYC = 40;
  localparam int BASE = int'(prpc_pkg::SPACING_IND_CYC);
  logic core_clk_i;
  logic rst_n_i;
  logic hw_rst_n;
  logic lclk, cs_n, wr, rsel, vld, read_write_strobe, oe, xlat, busy, wb, cstop, stby, sleep;
  logic [15:0] wd, ricfg, pcfg;
  logic [prpc_pkg::ROW_W-1:0] row, wrow, rrow;
  logic mon, b_seen, s_seen, w_seen, bsy_d;
  int fail_count;
  int tests_run;
  int c;
  int n_ref;
  logic [15:0] wr_tab [4] = '{16'h0003, 16'h0000, 16'h0001, 16'h0002};
  int mul_tab [4] = '{3, 4, 8, 2};
  prpc_host_model u_host (
    .link_clk_o(lclk), .cs_n_o(cs_n), .reg_wr_o(wr), .reg_sel_o(rsel),
    .reg_wdata_o(wd), .ca_row_vld_o(vld), .ca_row_o(row)
  );
  prpc_refresh_power_ctrl #(.SLEEP_EXIT_CYCLES(EXIT_CYC), .PLUS_RANGE(1'b0)) u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_clk_i(lclk), .cs_n_i(cs_n),
    .hw_reset_n_i(hw_rst_n), .reg_wr_i(wr), .reg_sel_refresh_i(rsel), .reg_wdata_i(wd),
    .ca_row_vld_i(vld), .ca_row_i(row), .read_write_strobe_o(read_write_strobe), .read_write_strobe_oe_o(oe),
    .extra_latency_o(xlat), .refresh_busy_o(busy), .refresh_row_o(rrow),
    .row_writeback_o(wb), .writeback_row_o(wrow), .clock_stop_o(cstop),
    .standby_o(stby), .deep_sleep_o(sleep), .refresh_interval_config_o(ricfg),
    .primary_config_o(pcfg)
  );
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (mon) begin
      b_seen <= b_seen | busy;
      s_seen <= s_seen | cstop;
    end
    if (wb) begin
      w_seen <= 1'b1;
    end
    // refreshes started since reset, to follow the row pointer
    bsy_d <= busy;
    if (busy && !bsy_d) begin
      n_ref <= n_ref + 1;
    end
  end
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task bad(input string m);
    fail_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : bad
  task cmp_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad($sformatf("value %h, wanted %h", got, exp));
    end
  endtask : cmp_word
  task cmp_cnt(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      bad($sformatf("count %0d outside %0d..%0d", got, lo, hi));
    end
  endtask : cmp_cnt
  task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
    c = 0;
    while (s !== lvl) begin
      @(posedge core_clk_i);
      #1;
      c++;
      if (c > lim) begin
        bad("wait ran out");
        close_out();
      end
    end
  endtask : wait_lvl
  // leaves c at the cycles from one refresh start to the next
  task measure;
    int a;
    wait_lvl(busy, 1'b0, 3000);
    a = c;
    wait_lvl(busy, 1'b1, 3000);
    c = c + a;
  endtask : measure
  task settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : settle
  task probe(input logic [15:0] exp);
    fork
      u_host.frame(1'b0, 1'b0, 1'b0, 16'h0123, 3, 0, 2);
      begin
        wait_lvl(oe, 1'b1, 20);
        cmp_word({15'h0, read_write_strobe}, exp);
        cmp_word({15'h0, xlat}, exp);
      end
    join
  endtask : probe
  task pulse_hw;
    hw_rst_n = 1'b0;
    settle(10);
    hw_rst_n = 1'b1;
    settle(12);
  endtask : pulse_hw
  initial begin
    rst_n_i = 1'b0;
    hw_rst_n = 1'b1;
    mon = 1'b0;
    b_seen = 1'b0;
    s_seen = 1'b0;
    w_seen = 1'b0;
    fail_count = 0;
    tests_run = 0;
    n_ref = 0;
    #3;
    // link-side flops need running edges while reset is low
    u_host.tick(6);
    settle(1);
    rst_n_i = 1'b1;
    // link reset releases only on link edges, before the first write
    u_host.tick(6);
    settle(4);
    cmp_word(pcfg, 16'h8008);
    cmp_word(ricfg, 16'h0002);
    cmp_word({15'h0, stby}, 16'h0001);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      u_host.frame(1'b0, 1'b1, 1'b1, wr_tab[i], 3, 0, 2);
      settle(12);
      cmp_word(ricfg, {14'h0, wr_tab[i][1:0]});
      repeat (3) measure();
      cmp_cnt(c, BASE * mul_tab[i] / 2, BASE * mul_tab[i] / 2);
    end
    $display("test interval done");
    u_host.frame(1'b1, 1'b1, 1'b1, 16'h0001, 3, 0, 2);
    settle(12);
    cmp_word(ricfg, 16'h0002);
    $display("test deselect done");
    u_host.frame(1'b0, 1'b1, 1'b0, 16'h8000, 3, 0, 2);
    settle(12);
    cmp_word(pcfg, 16'h8000);
    repeat (2) measure();
    settle(BASE - 4);
    probe(16'h0001);
    repeat (2) measure();
    settle(20);
    probe(16'h0000);
    cmp_word({3'h0, rrow}, {3'h0, 13'(n_ref)});
    $display("test latency done");
    repeat (2) measure();
    settle(BASE - 100);
    w_seen = 1'b0;
    s_seen = 1'b0;
    b_seen = 1'b0;
    mon = 1'b1;
    u_host.frame(1'b0, 1'b0, 1'b0, 16'h1ABC, 20, 200, 20);
    mon = 1'b0;
    cmp_word({15'h0, b_seen}, 16'h0000);
    cmp_word({15'h0, s_seen}, 16'h0001);
    cmp_word({15'h0, cstop}, 16'h0000);
    wait_lvl(busy, 1'b1, 30);
    cmp_word({15'h0, w_seen}, 16'h0001);
    cmp_word({3'h0, wrow}, 16'h1ABC);
    $display("test long access done");
    u_host.frame(1'b0, 1'b1, 1'b0, 16'h0000, 3, 0, 2);
    wait_lvl(sleep, 1'b1, 1400);
    cmp_cnt(c, 1200, 1300);
    b_seen = 1'b0;
    mon = 1'b1;
    settle(BASE + 100);
    mon = 1'b0;
    cmp_word({15'h0, b_seen}, 16'h0000);
    u_host.frame(1'b0, 1'b1, 1'b1, 16'h0001, 7, 0, 2);
    wait_lvl(sleep, 1'b0, EXIT_CYC + 30);
    cmp_word(pcfg, 16'h8008);
    cmp_word(ricfg, 16'h0002);
    $display("test deep sleep done");
    u_host.frame(1'b0, 1'b1, 1'b1, 16'h0001, 3, 0, 2);
    settle(12);
    cmp_word(ricfg, 16'h0001);
    pulse_hw();
    cmp_word(ricfg, 16'h0002);
    u_host.frame(1'b0, 1'b1, 1'b0, 16'h0000, 3, 0, 2);
    wait_lvl(sleep, 1'b1, 1400);
    pulse_hw();
    wait_lvl(sleep, 1'b0, EXIT_CYC + 30);
    cmp_word(pcfg, 16'h8008);
    $display("test hardware reset done");
    close_out();
  end
endmodule : prpc_refresh_power_ctrl_tb_top
